//--- async_serial_port_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_defines.svh"
module async_serial_port_regs
	import serial_port_pkg::*;
#(
	parameter int FIFO_DEPTH = `FIFO_DEPTH_DEF
)(
	input  wire logic        clock,
	input  wire logic        nrst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        serial_input,
	output logic             serial_output,
	output logic             infrared_transmit_output,
	input  wire logic        cts_n,
	input  wire logic        dsr_n,
	input  wire logic        ri_n,
	input  wire logic        dcd_n,
	output logic             rts_n,
	output logic             dtr_n,
	output logic             irq
);
	localparam int CW = $clog2(FIFO_DEPTH) + 1;
	generate
		if (FIFO_DEPTH < 16 || FIFO_DEPTH > 256)
		begin : g_bad
			$error("FIFO_DEPTH must lie in 16..256");
		end
	endgenerate

	function automatic logic par_fn(input logic [7:0] d,
		input logic [3:0] n, input logic [7:0] lf);
		logic [7:0] m;
		m = d & 8'(8'hff >> (4'h8 - n));
		if (lf[`LF_FIXP])
			par_fn = !lf[`LF_EVEN];
		else
			par_fn = lf[`LF_EVEN] ? ^m : ~^m;
	endfunction : par_fn

	// ----------------------------------------
	// reset release
	// ----------------------------------------
	logic rst1_n_r;
	logic rst_n_r;
	always_ff @(posedge clock or negedge nrst)
		if (!nrst)
			{rst_n_r, rst1_n_r} <= 2'b00;
		else
			{rst_n_r, rst1_n_r} <= {rst1_n_r, 1'b1};

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	logic [7:0]  lfmt_r;
	logic [4:0]  mctl_r;
	logic [3:0]  ien_r;
	logic [7:0]  scr_r;
	logic [15:0] div_r;
	logic        fifo_en_r;
	logic [1:0]  trig_r;

	wire       dlab     = lfmt_r[`LF_DLAB];
	wire       loop     = mctl_r[`MC_LOOP];
	wire [3:0] nbits    = 4'h5 + {2'b00, lfmt_r[1:0]};
	wire [5:0] stop_len = !lfmt_r[`LF_STOP] ? `BIT_TICKS :
		(lfmt_r[1:0] == 2'b00) ? `STOP15_TICKS : `STOP2_TICKS;

	// ----------------------------------------
	// bus slave
	// ----------------------------------------
	wire       ahb_go = hsel && htrans[1] && hready && hsize == 3'h2;
	wire       mapped = (haddr[31:5] == 27'h0);
	wire [2:0] idx    = haddr[4:2];
	wire       rd_go  = ahb_go && !hwrite && mapped;
	logic      wr_pend_r;
	logic [2:0] wr_idx_r;
	wire [7:0] wd     = hwdata[7:0];

	function automatic logic hit(input logic g, input logic [2:0] a,
		input logic [2:0] i);
		hit = g && (a == i);
	endfunction : hit

	wire rd_rx    = hit(rd_go, idx, `IDX_DATA) && !dlab;
	wire rd_istat = hit(rd_go, idx, `IDX_ISTAT);
	wire rd_lstat = hit(rd_go, idx, `IDX_LSTAT);
	wire rd_mstat = hit(rd_go, idx, `IDX_MSTAT);
	wire wr_tx    = hit(wr_pend_r, wr_idx_r, `IDX_DATA) && !dlab;
	wire wr_fc    = hit(wr_pend_r, wr_idx_r, `IDX_ISTAT);

	// ----------------------------------------
	// 16x tick
	// ----------------------------------------
	logic [15:0] baud_cnt_r;
	wire  [15:0] div_m1 = (div_r == 16'h0000) ? 16'h0000 : div_r - 16'h0001;
	wire         tick16 = (baud_cnt_r >= div_m1);

	always_ff @(posedge clock or negedge rst_n_r)
		if (!rst_n_r)
			baud_cnt_r <= 16'h0000;
		else
			baud_cnt_r <= tick16 ? 16'h0000 : baud_cnt_r + 16'h0001;

	// ----------------------------------------
	// fifos
	// ----------------------------------------
	logic          tx_valid;
	logic          tx_in_ready;
	logic [7:0]    tx_data;
	logic          rx_valid;
	logic          rx_in_ready;
	logic [10:0]   rx_head;
	logic [CW-1:0] rx_level;
	logic [10:0]   rx_word;
	logic          rx_done;
	tx_state_e     tx_st_r;

	// outside FIFO mode each path holds a single byte
	wire tx_room = fifo_en_r ? tx_in_ready : !tx_valid;
	wire rx_room = fifo_en_r ? rx_in_ready : !rx_valid;
	wire tx_pop  = tx_st_r == TX_IDLE;
	wire rx_pop  = rd_rx && rx_valid;

	serial_fifo_mem #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
		.clock     (clock),
		.rst_n     (rst_n_r),
		.clear     (wr_fc && wd[`FC_TXCLR]),
		.in_valid  (wr_tx && tx_room),
		.in_ready  (tx_in_ready),
		.in_data   (wd),
		.out_valid (tx_valid),
		.out_ready (tx_pop),
		.out_data  (tx_data),
		.level     ()
	);

	serial_fifo_mem #(.WIDTH(11), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
		.clock     (clock),
		.rst_n     (rst_n_r),
		.clear     (wr_fc && wd[`FC_RXCLR]),
		.in_valid  (rx_done && rx_room),
		.in_ready  (rx_in_ready),
		.in_data   (rx_word),
		.out_valid (rx_valid),
		.out_ready (rx_pop),
		.out_data  (rx_head),
		.level     (rx_level)
	);

	// ----------------------------------------
	// transmitter
	// ----------------------------------------
	logic [7:0] tx_sh_r;
	logic [2:0] tx_bit_r;
	logic [5:0] tx_tck_r;
	logic       tx_par_r;
	tx_state_e  tx_st_nxt;
	wire        tx_bit_end = tick16 && tx_tck_r == `BIT_TICKS - 6'h01;
	wire        tx_last    = tx_bit_r == 3'(nbits - 4'h1);
	wire        tx_line    = tx_st_r == TX_START ? 1'b0 :
		tx_st_r == TX_DATA ? tx_sh_r[0] :
		tx_st_r == TX_PAR ? tx_par_r : 1'b1;

	always_comb
	begin
		tx_st_nxt = tx_st_r;
		case (tx_st_r)
		TX_IDLE:
			if (tx_valid)
				tx_st_nxt = TX_START;
		TX_START:
			if (tx_bit_end)
				tx_st_nxt = TX_DATA;
		TX_DATA:
			if (tx_bit_end && tx_last)
				tx_st_nxt = lfmt_r[`LF_PEN] ? TX_PAR : TX_STOP;
		TX_PAR:
			if (tx_bit_end)
				tx_st_nxt = TX_STOP;
		default:
			if (tick16 && tx_tck_r == stop_len - 6'h01)
				tx_st_nxt = TX_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge rst_n_r)
		if (!rst_n_r)
		begin
			tx_st_r  <= TX_IDLE;
			tx_sh_r  <= 8'h00;
			tx_bit_r <= 3'h0;
			tx_tck_r <= 6'h00;
			tx_par_r <= 1'b0;
		end
		else
		begin
			tx_st_r  <= tx_st_nxt;
			// stop may span 24 or 32 ticks: its count must not wrap at 16
			tx_tck_r <= (tx_st_nxt != tx_st_r ||
				(tx_bit_end && tx_st_r != TX_STOP)) ? 6'h00 :
				tx_tck_r + 6'(tick16);
			if (tx_st_r == TX_IDLE)
			begin
				tx_sh_r  <= tx_data;
				tx_bit_r <= 3'h0;
				tx_par_r <= par_fn(tx_data, nbits, lfmt_r);
			end
			else if (tx_st_r == TX_DATA && tx_bit_end)
			begin
				tx_sh_r  <= {1'b0, tx_sh_r[7:1]};
				tx_bit_r <= tx_bit_r + 3'h1;
			end
		end

	// ----------------------------------------
	// receiver
	// ----------------------------------------
	rx_state_e  rx_st_r;
	logic [3:0] rx_tck_r;
	logic [7:0] rx_sh_r;
	logic [2:0] rx_bit_r;
	logic       rx_perr_r;
	logic       rx_any_r;
	wire        rx_in   = loop ? tx_line : serial_input;
	wire        rx_mid  = tick16 && rx_tck_r == 4'hf;
	wire [7:0]  rx_byte = 8'(rx_sh_r >> (4'h8 - nbits));
	assign rx_done = rx_st_r == RX_STOP && rx_mid;
	assign rx_word = {!rx_any_r && !rx_in, !rx_in, rx_perr_r, rx_byte};

	always_ff @(posedge clock or negedge rst_n_r)
		if (!rst_n_r)
		begin
			rx_st_r   <= RX_IDLE;
			rx_tck_r  <= 4'h0;
			rx_sh_r   <= 8'h00;
			rx_bit_r  <= 3'h0;
			rx_perr_r <= 1'b0;
			rx_any_r  <= 1'b0;
		end
		else
		begin
			rx_tck_r <= rx_st_r == RX_IDLE ? 4'h0 : rx_tck_r + 4'(tick16);
			case (rx_st_r)
			RX_IDLE:
				if (!rx_in)
					rx_st_r <= RX_START;
			RX_START:
				if (tick16 && rx_tck_r == `MID_TICK)
				begin
					rx_st_r   <= rx_in ? RX_IDLE : RX_DATA;
					rx_tck_r  <= 4'h0;
					rx_bit_r  <= 3'h0;
					rx_perr_r <= 1'b0;
					rx_any_r  <= 1'b0;
				end
			RX_DATA:
				if (rx_mid)
				begin
					rx_sh_r  <= {rx_in, rx_sh_r[7:1]};
					rx_bit_r <= rx_bit_r + 3'h1;
					rx_any_r <= rx_any_r | rx_in;
					if (rx_bit_r == 3'(nbits - 4'h1))
						rx_st_r <= lfmt_r[`LF_PEN] ? RX_PAR : RX_STOP;
				end
			RX_PAR:
				if (rx_mid)
				begin
					rx_perr_r <= rx_in != par_fn(rx_byte, nbits, lfmt_r);
					rx_any_r  <= rx_any_r | rx_in;
					rx_st_r   <= RX_STOP;
				end
			default:
				if (rx_mid)
					rx_st_r <= RX_IDLE;
			endcase
		end

	// ----------------------------------------
	// status, modem lines, interrupt
	// ----------------------------------------
	logic [3:0]    lerr_r;
	logic [3:0]    mdelta_r;
	logic [3:0]    mprev_r;
	logic          thre_int_r;
	logic          tx_empty_d_r;
	logic [CW-1:0] err_cnt_r;
	// bit order dcd, ri, dsr, cts
	wire [3:0] mlines = loop ? {mctl_r[3], mctl_r[2], mctl_r[0], mctl_r[1]} :
		~{dcd_n, ri_n, dsr_n, cts_n};
	wire [3:0] mset   = {mlines[3] ^ mprev_r[3], !mlines[2] && mprev_r[2],
		mlines[1:0] ^ mprev_r[1:0]};
	wire       tx_empty = !tx_valid;
	wire       rx_err   = rx_done && (|rx_word[10:8]);
	wire [3:0] lset     = {rx_word[10:8] & {3{rx_done}}, rx_done && !rx_room};
	wire       rfe      = fifo_en_r && err_cnt_r != '0;
	wire [4:0] trig     = trig_r == 2'h0 ? `TRIG_1 : trig_r == 2'h1 ? `TRIG_4 :
		trig_r == 2'h2 ? `TRIG_8 : `TRIG_14;
	wire       ls_int   = ien_r[2] && |lerr_r;
	wire       rx_int   = ien_r[0] && (fifo_en_r ?
		rx_level >= CW'(trig) : rx_valid);
	wire       tx_int   = ien_r[1] && thre_int_r;
	wire       ms_int   = ien_r[3] && |mdelta_r;
	wire       pend     = ls_int || rx_int || tx_int || ms_int;
	wire [1:0] int_id   = ls_int ? `ID_LINE : rx_int ? `ID_RX :
		tx_int ? `ID_TX : `ID_MODEM;

	always_ff @(posedge clock or negedge rst_n_r)
		if (!rst_n_r)
		begin
			lerr_r       <= 4'h0;
			mdelta_r     <= 4'h0;
			mprev_r      <= 4'h0;
			thre_int_r   <= 1'b0;
			tx_empty_d_r <= 1'b1;
			err_cnt_r    <= '0;
		end
		else
		begin
			// a new event wins over the clear by reading
			lerr_r       <= lset | (lerr_r & {4{!rd_lstat}});
			mdelta_r     <= mset | (mdelta_r & {4{!rd_mstat}});
			mprev_r      <= mlines;
			tx_empty_d_r <= tx_empty;
			thre_int_r   <= (tx_empty && !tx_empty_d_r) | (thre_int_r &&
				!wr_tx && !(rd_istat && pend && int_id == `ID_TX));
			if (wr_fc && wd[`FC_RXCLR])
				err_cnt_r <= '0;
			else
				err_cnt_r <= err_cnt_r + CW'(rx_err && rx_room)
					- CW'(rx_pop && |rx_head[10:8]);
		end

	// ----------------------------------------
	// register writes and read data
	// ----------------------------------------
	logic [7:0] rdata;
	always_comb
	begin
		rdata = 8'h00;
		if (idx == `IDX_DATA)
			rdata = dlab ? div_r[7:0] : rx_head[7:0];
		else if (idx == `IDX_IEN)
			rdata = dlab ? div_r[15:8] : {4'h0, ien_r};
		else if (idx == `IDX_ISTAT)
			rdata = {{2{fifo_en_r}}, 3'b000, int_id, !pend};
		else if (idx == `IDX_LFMT)
			rdata = lfmt_r;
		else if (idx == `IDX_MCTL)
			rdata = {3'b000, mctl_r};
		else if (idx == `IDX_LSTAT)
			rdata = {rfe, tx_empty && tx_st_r == TX_IDLE, tx_empty,
				lerr_r[3:1], lerr_r[0], rx_valid};
		else if (idx == `IDX_MSTAT)
			rdata = {mlines, mdelta_r};
		else
			rdata = scr_r;
	end

	always_ff @(posedge clock or negedge rst_n_r)
		if (!rst_n_r)
		begin
			wr_pend_r <= 1'b0;
			wr_idx_r  <= 3'h0;
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b0;
			hresp     <= 1'b0;
		end
		else
		begin
			wr_pend_r <= ahb_go && hwrite && mapped;
			wr_idx_r  <= idx;
			hrdata    <= rd_go ? {24'h00_0000, rdata} : 32'h0000_0000;
			hreadyout <= 1'b1;
		end

	always_ff @(posedge clock or negedge rst_n_r)
		if (!rst_n_r)
		begin
			lfmt_r    <= `LFMT_RST;
			mctl_r    <= `MCTL_RST;
			ien_r     <= `IEN_RST;
			scr_r     <= `SCR_RST;
			div_r     <= `DIV_RST;
			fifo_en_r <= 1'b0;
			trig_r    <= 2'h0;
		end
		else if (wr_pend_r)
		begin
			if (wr_idx_r == `IDX_DATA && dlab)
				div_r[7:0] <= wd;
			else if (wr_idx_r == `IDX_IEN && dlab)
				div_r[15:8] <= wd;
			else if (wr_idx_r == `IDX_IEN)
				ien_r <= wd[3:0];
			else if (wr_idx_r == `IDX_ISTAT)
			begin
				fifo_en_r <= wd[`FC_EN];
				trig_r    <= wd[7:6];
			end
			else if (wr_idx_r == `IDX_LFMT)
				lfmt_r <= wd;
			else if (wr_idx_r == `IDX_MCTL)
				mctl_r <= wd[4:0];
			else if (wr_idx_r == `IDX_SCR)
				scr_r <= wd;
		end

	// ----------------------------------------
	// pins
	// ----------------------------------------
	// silence only masks the pins; the frame engine keeps its timing
	wire line_out = lfmt_r[`LF_SIL] ? 1'b0 : loop ? 1'b1 : tx_line;
	always_ff @(posedge clock or negedge rst_n_r)
		if (!rst_n_r)
		begin
			serial_output            <= 1'b1;
			infrared_transmit_output <= 1'b1;
			rts_n                    <= 1'b1;
			dtr_n                    <= 1'b1;
			irq                      <= 1'b0;
		end
		else
		begin
			serial_output            <= line_out;
			infrared_transmit_output <= line_out;
			rts_n                    <= loop || !mctl_r[1];
			dtr_n                    <= loop || !mctl_r[0];
			irq                      <= pend && mctl_r[`MC_IRQEN];
		end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking dc @(posedge clock); endclocking
	default disable iff (!rst_n_r);

	AST_SILENCE: assert property (lfmt_r[6] |=> !serial_output)
		else $error("silence did not hold line low");
	AST_KEEP_RUN: assert property (
		lfmt_r[6] && tx_st_r == TX_IDLE && tx_valid
		|=> tx_st_r == TX_START)
		else $error("silence stalled transmitter");
	AST_START_LOW: assert property (
		tx_st_r == TX_START && !lfmt_r[6] && !loop
		|=> !serial_output)
		else $error("start bit not low");
	AST_LSB_FIRST: assert property (
		tx_st_r == TX_IDLE && tx_valid
		|=> tx_sh_r == $past(tx_data) && tx_bit_r == 3'h0)
		else $error("byte not loaded lsb first");
	AST_FIX_PAR: assert property (
		tx_st_r == TX_PAR && lfmt_r[3] && lfmt_r[5]
		|-> tx_line == !lfmt_r[4])
		else $error("fixed parity wrong");
	AST_WLEN: assert property (
		tx_st_r == TX_DATA && tx_bit_end && tx_bit_r == 3'(nbits - 4'h1)
		|=> tx_st_r != TX_DATA)
		else $error("data length wrong");
	AST_DIV_READ: assert property (
		rd_go && idx == 3'h0 && dlab
		|=> hrdata[7:0] == $past(div_r[7:0]))
		else $error("divisor low not read");
	AST_RX_READ: assert property (
		rd_go && idx == 3'h0 && !dlab && rx_valid
		|=> hrdata[7:0] == $past(rx_head[7:0]))
		else $error("receive byte not read");
	AST_COMPAT: assert property (
		rd_go && idx == 3'h2 && !fifo_en_r
		|=> hrdata[7:6] == 2'b00 && !hrdata[3])
		else $error("fifo bits set in compatible mode");
	AST_TICK: assert property (
		tick16 && div_m1 != 16'h0000 |=> !tick16)
		else $error("tick faster than divisor");
	AST_RX_PUSH: assert property (
		rx_done && rx_room && !(wr_fc && wd[`FC_RXCLR]) |=> rx_valid)
		else $error("received byte lost");

	COV_TX_FRAME: cover property (tx_st_r == TX_STOP ##1 tx_st_r == TX_IDLE);
	COV_RX_BYTE: cover property (rx_done && !rx_err);
	COV_OVERRUN: cover property (rx_done && !rx_room);
	COV_IRQ: cover property ($rose(irq));
endmodule : async_serial_port_regs
`default_nettype wire

//--- serial_port_defines.svh
`ifndef SERIAL_PORT_DEFINES_SVH
`define SERIAL_PORT_DEFINES_SVH

// ----------------------------------------
// register indices, byte address = 4 * index
// ----------------------------------------
`define IDX_DATA   3'h0
`define IDX_IEN    3'h1
`define IDX_ISTAT  3'h2
`define IDX_LFMT   3'h3
`define IDX_MCTL   3'h4
`define IDX_LSTAT  3'h5
`define IDX_MSTAT  3'h6
`define IDX_SCR    3'h7

// ----------------------------------------
// field positions
// ----------------------------------------
`define LF_DLAB    7
`define LF_SIL     6
`define LF_FIXP    5
`define LF_EVEN    4
`define LF_PEN     3
`define LF_STOP    2
`define MC_LOOP    4
`define MC_IRQEN   3
`define FC_EN      0
`define FC_RXCLR   1
`define FC_TXCLR   2

// ----------------------------------------
// reset values
// ----------------------------------------
`define LFMT_RST   8'h00
`define MCTL_RST   5'h00
`define IEN_RST    4'h0
`define SCR_RST    8'h00
`define DIV_RST    16'h0001

// ----------------------------------------
// timing in 16x ticks, fifo depth and trigger levels, interrupt ids
// ----------------------------------------
`define BIT_TICKS    6'h10
`define MID_TICK     4'h7
`define STOP15_TICKS 6'h18
`define STOP2_TICKS  6'h20
`define FIFO_DEPTH_DEF 16
`define TRIG_1     5'h01
`define TRIG_4     5'h04
`define TRIG_8     5'h08
`define TRIG_14    5'h0e
`define ID_LINE    2'h3
`define ID_RX      2'h2
`define ID_TX      2'h1
`define ID_MODEM   2'h0

`endif

//--- serial_port_pkg.sv
package serial_port_pkg;
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP}
		tx_state_e;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP}
		rx_state_e;
endpackage : serial_port_pkg

//--- serial_fifo_mem.sv
`timescale 1ns/1ps
`default_nettype none
module serial_fifo_mem #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16,
	localparam int AW = $clog2(DEPTH),
	localparam int CW = AW + 1
)(
	input  wire logic             clock,
	input  wire logic             rst_n,
	input  wire logic             clear,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic      [CW-1:0]    level
);
	generate
		if (DEPTH < 2 || (1 << AW) != DEPTH)
		begin : g_bad
			$error("depth must be a power of two, at least 2");
		end
	endgenerate

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    rd_r;
	logic [AW-1:0]    wr_r;
	logic [CW-1:0]    cnt_r;

	wire          push   = in_valid && in_ready;
	wire          pop    = out_valid && out_ready;
	wire [AW-1:0] rd_nxt = pop ? rd_r + 1'b1 : rd_r;
	// head word is kept in a register; a write into the head slot bypasses
	wire          bypass = push && (wr_r == rd_nxt);

	assign in_ready  = (cnt_r != CW'(DEPTH));
	assign out_valid = (cnt_r != '0);
	assign level     = cnt_r;

	always_ff @(posedge clock)
		if (push)
			mem[wr_r] <= in_data;

	always_ff @(posedge clock or negedge rst_n)
		if (!rst_n)
		begin
			rd_r     <= '0;
			wr_r     <= '0;
			cnt_r    <= '0;
			out_data <= '0;
		end
		else if (clear)
		begin
			rd_r  <= '0;
			wr_r  <= '0;
			cnt_r <= '0;
		end
		else
		begin
			rd_r     <= rd_nxt;
			wr_r     <= push ? wr_r + 1'b1 : wr_r;
			cnt_r    <= cnt_r + CW'(push) - CW'(pop);
			out_data <= bypass ? in_data : mem[rd_nxt];
		end

	AST_NO_OVERFILL: assert property (
		@(posedge clock) disable iff (!rst_n)
		(cnt_r == CW'(DEPTH) && !pop && !clear)
		|=> cnt_r == CW'(DEPTH))
		else $error("fifo level changed while full");
endmodule : serial_fifo_mem
`default_nettype wire

//--- serial_peer.sv
`timescale 1ns/1ps
`default_nettype none
module serial_peer #(
	parameter int BIT_CLKS = 32
)(
	input  wire logic clock,
	input  wire logic line_in,
	output logic      line_out
);
	// line has a pull-up, so it rests high between frames
	initial line_out = 1'b1;

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask : tick

	task automatic send(input logic [7:0] d, input int nb);
		line_out <= 1'b0;
		tick(BIT_CLKS);
		for (int i = 0; i < nb; i++)
		begin
			line_out <= d[i];
			tick(BIT_CLKS);
		end
		line_out <= 1'b1;
		tick(2 * BIT_CLKS);
	endtask : send

	task automatic recv(input int nb, input logic pen,
		output logic [7:0] d, output logic p, output logic ok);
		int k;
		d = 8'h00;
		k = 0;
		while (line_in === 1'b1 && k < 40 * BIT_CLKS)
		begin
			@(posedge clock);
			k++;
		end
		// sample mid-bit, clear of edge skew
		tick(BIT_CLKS / 2);
		ok = (line_in === 1'b0);
		for (int i = 0; i < nb; i++)
		begin
			tick(BIT_CLKS);
			d[i] = line_in;
		end
		tick(pen ? BIT_CLKS : 0);
		p = line_in;
		tick(BIT_CLKS);
		ok = ok && (line_in === 1'b1);
	endtask : recv
endmodule : serial_peer
`default_nettype wire

//--- test_async_serial_port_regs.sv
`timescale 1ns/1ps
`default_nettype none
module test_async_serial_port_regs;
	typedef struct packed
	{
		logic       w;
		logic [7:0] a;
		logic [7:0] d;
		logic [7:0] m;
	} row_s;
	localparam row_s ROWS [21] = '{
		'{1'b0, 8'h0c, 8'h00, 8'hff}, '{1'b0, 8'h10, 8'h00, 8'hff},
		'{1'b1, 8'h1c, 8'ha5, 8'h00}, '{1'b0, 8'h1c, 8'ha5, 8'hff},
		'{1'b1, 8'h0c, 8'h80, 8'h00}, '{1'b1, 8'h00, 8'h34, 8'h00},
		'{1'b1, 8'h04, 8'h12, 8'h00}, '{1'b0, 8'h00, 8'h34, 8'hff},
		'{1'b0, 8'h04, 8'h12, 8'hff}, '{1'b1, 8'h04, 8'h00, 8'h00},
		'{1'b1, 8'h00, 8'h02, 8'h00}, '{1'b1, 8'h0c, 8'h03, 8'h00},
		'{1'b1, 8'h04, 8'hff, 8'h00}, '{1'b0, 8'h04, 8'h0f, 8'hff},
		'{1'b1, 8'h04, 8'h00, 8'h00}, '{1'b0, 8'h08, 8'h00, 8'hc8},
		'{1'b0, 8'h20, 8'h00, 8'hff}, '{1'b1, 8'h08, 8'h01, 8'h00},
		'{1'b0, 8'h08, 8'hc0, 8'hc0}, '{1'b1, 8'h08, 8'h06, 8'h00},
		'{1'b0, 8'h08, 8'h00, 8'hc8}};
	localparam logic [7:0] FMT [4] = '{8'h00, 8'h19, 8'h0a, 8'h3f};
	logic        clock;
	logic        nrst;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        serial_input;
	logic        serial_output;
	logic        ir_out;
	logic        cts_n;
	logic        ri_n;
	logic        rts_n;
	logic        dtr_n;
	logic        irq;
	logic [31:0] rd;
	logic [7:0]  rx_d;
	logic [7:0]  dm;
	logic        rx_p;
	logic        rx_ok;
	logic        ep;
	int          n_fail;
	int          checks_done;

	async_serial_port_regs u_dut (.clock(clock), .nrst(nrst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .serial_input(serial_input),
		.serial_output(serial_output), .infrared_transmit_output(ir_out),
		.cts_n(cts_n), .dsr_n(1'b1), .ri_n(ri_n), .dcd_n(1'b1),
		.rts_n(rts_n), .dtr_n(dtr_n), .irq(irq));
	serial_peer #(.BIT_CLKS(32)) u_peer (.clock(clock),
		.line_in(serial_output), .line_out(serial_input));

	// ----------------------------------------
	// checking and bus tasks
	// ----------------------------------------
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : tally_and_finish

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp

	task automatic cmp_bit(input logic got, input logic exp);
		cmp({31'h0000_0000, got}, {31'h0000_0000, exp});
	endtask : cmp_bit

	task automatic bus(input logic w, input logic [7:0] a,
		input logic [7:0] d, output logic [31:0] r);
		int k;
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'h00_0000, a};
		k = 0;
		do
		begin
			@(posedge clock);
			k++;
		end while (hreadyout !== 1'b1 && k < 50);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {24'h00_0000, d};
		do
		begin
			@(posedge clock);
			k++;
		end while (hreadyout !== 1'b1 && k < 100);
		r = hrdata;
		if (k >= 100)
		begin
			n_fail++;
			tally_and_finish();
		end
		// idle cycle so a dependent read sees the new value
		@(posedge clock);
	endtask : bus

	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	initial
	begin
		repeat (100000) @(posedge clock);
		n_fail++;
		tally_and_finish();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		nrst = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0000_0000;
		cts_n = 1'b1;
		ri_n = 1'b1;
		n_fail = 0;
		checks_done = 0;
		repeat (8) @(posedge clock);
		cmp_bit(hreadyout, 1'b0);
		cmp_bit(serial_output, 1'b1);
		nrst <= 1'b1;
		repeat (6) @(posedge clock);
		cmp_bit(hreadyout, 1'b1);
		for (int i = 0; i < 21; i++)
		begin
			bus(ROWS[i].w, ROWS[i].a, ROWS[i].d, rd);
			if (!ROWS[i].w)
				cmp(rd & {24'hff_ffff, ROWS[i].m}, {24'h00_0000, ROWS[i].d & ROWS[i].m});
		end
		cmp_bit(hresp, 1'b0);
		for (int l = 0; l < 4; l++)
		begin
			bus(1'b1, 8'h0c, FMT[l], rd);
			bus(1'b1, 8'h00, 8'ha5, rd);
			u_peer.recv(5 + l, FMT[l][3], rx_d, rx_p, rx_ok);
			dm = 8'ha5 & (8'hff >> (3 - l));
			ep = FMT[l][5] ? ~FMT[l][4] : (FMT[l][4] ? ^dm : ~^dm);
			cmp({24'h00_0000, rx_d}, {24'h00_0000, dm});
			if (FMT[l][3])
				cmp_bit(rx_p, ep);
			cmp_bit(rx_ok, 1'b1);
			repeat (96) @(posedge clock);
		end
		bus(1'b1, 8'h0c, 8'h43, rd);
		bus(1'b1, 8'h00, 8'h3c, rd);
		// data bit 2 of the frame is high, so only silence keeps the pin low
		repeat (110) @(posedge clock);
		cmp_bit(serial_output, 1'b0);
		cmp_bit(ir_out, 1'b0);
		repeat (570) @(posedge clock);
		bus(1'b0, 8'h14, 8'h00, rd);
		cmp(rd & 32'h0000_0060, 32'h0000_0060);
		bus(1'b1, 8'h0c, 8'h03, rd);
		u_peer.send(8'h5a, 8);
		u_peer.send(8'hc3, 8);
		bus(1'b0, 8'h14, 8'h00, rd);
		cmp(rd & 32'h0000_0003, 32'h0000_0003);
		bus(1'b0, 8'h00, 8'h00, rd);
		cmp(rd, 32'h0000_005a);
		cts_n <= 1'b0;
		bus(1'b1, 8'h10, 8'h0b, rd);
		bus(1'b1, 8'h04, 8'h02, rd);
		repeat (4) @(posedge clock);
		cmp_bit(rts_n, 1'b0);
		cmp_bit(dtr_n, 1'b0);
		cmp_bit(irq, 1'b1);
		bus(1'b0, 8'h18, 8'h00, rd);
		cmp(rd & 32'h0000_0010, 32'h0000_0010);
		bus(1'b1, 8'h04, 8'h00, rd);
		repeat (4) @(posedge clock);
		cmp_bit(irq, 1'b0);
		// fifo mode, trigger level 4, receive fifo cleared
		bus(1'b1, 8'h08, 8'h43, rd);
		bus(1'b1, 8'h04, 8'h01, rd);
		for (int i = 0; i < 4; i++)
		begin
			cmp_bit(irq, 1'b0);
			u_peer.send(8'h10 + 8'(i), 8);
		end
		cmp_bit(irq, 1'b1);
		for (int i = 0; i < 4; i++)
		begin
			bus(1'b0, 8'h00, 8'h00, rd);
			cmp(rd, 32'h0000_0010 + 32'(i));
		end
		ri_n <= 1'b0;
		repeat (4) @(posedge clock);
		ri_n <= 1'b1;
		repeat (4) @(posedge clock);
		bus(1'b0, 8'h18, 8'h00, rd);
		cmp(rd & 32'h0000_0004, 32'h0000_0004);
		// loopback: line forced high, receiver hears the transmitter
		bus(1'b1, 8'h10, 8'h13, rd);
		bus(1'b1, 8'h00, 8'h96, rd);
		repeat (40) @(posedge clock);
		cmp_bit(serial_output, 1'b1);
		cmp_bit(rts_n, 1'b1);
		repeat (360) @(posedge clock);
		bus(1'b0, 8'h00, 8'h00, rd);
		cmp(rd, 32'h0000_0096);
		bus(1'b0, 8'h18, 8'h00, rd);
		cmp(rd & 32'h0000_00f0, 32'h0000_0030);
		// reset in mid-run
		nrst <= 1'b0;
		repeat (2) @(posedge clock);
		cmp_bit(hreadyout, 1'b0);
		cmp_bit(serial_output, 1'b1);
		nrst <= 1'b1;
		repeat (6) @(posedge clock);
		bus(1'b0, 8'h10, 8'h00, rd);
		cmp(rd, 32'h0000_0000);
		bus(1'b0, 8'h0c, 8'h00, rd);
		cmp(rd, 32'h0000_0000);
		tally_and_finish();
	end
endmodule : test_async_serial_port_regs
`default_nettype wire
